// >>> rtl/sensor_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Self-test field resets 00, 01 plus, 10 minus
// - Per-axis tap enables, reset disabled
// - Latch bit: pulsed or latched event requests
// - Polarity bit: pads active high or low
// - Drive bit: push-pull or open-drain pads
// - Master data-ready routable to first pad
// - Tap, wakeup, fall, orientation routed to pad1
// - Level and data-ready routed to first pad
// - Data-ready latched at zero, pulsed at one
// - Boot state routable to second pad
// - Merge bit copies second pad onto first
// - Tilt, motion, step routed to second pad
// - Level and data-ready routed to second pad
// - Step overflow routable to second pad
// - Mode 000 bypass stores nothing
// - Mode 001 stops when full
// - Mode 110 overwrites oldest when full
// - Mode 011 streams until trigger falls, then collects until full
// - Mode 100 bypass until trigger falls, then collects
// - One entry per internal sample-ready event
// - Capacity 256 axis or 768 magnitude entries
module sensor_ctrl
  import sensor_ctrl_pkg::*;
#(
  parameter int AXIS_ENTRIES = sensor_ctrl_pkg::AXIS_DEPTH,
  parameter int MAG_ENTRIES = sensor_ctrl_pkg::MAG_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sensor_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Control from neighbouring blocks
  input wire logic softReset,
  input wire logic latchClear,
  input wire logic readyAck,
  // Detection events, one-cycle pulses
  input wire logic wakeupEvent,
  input wire logic singleTapEvent,
  input wire logic doubleTapEvent,
  input wire logic tiltEvent,
  input wire logic sigMotionEvent,
  input wire logic stepEvent,
  // Status levels
  input wire logic freefallLevel,
  input wire logic orientLevel,
  input wire logic masterReady,
  input wire logic bootBusy,
  input wire logic stepOverflow,
  input wire logic queueLevelHit,
  // Sample path and queue status
  input wire logic sampleReady,
  input wire logic queueFull,
  input wire logic queueTrigger,
  // Configuration outputs
  output logic [1:0] selfTestSelect,
  output logic [2:0] tapAxisEnable,
  output logic magnitudeToQueue,
  output logic [9:0] queueCapacity,
  output logic csPullupDisable,
  // Queue write control
  output logic queueEnabled,
  output logic queueWrite,
  output logic queueOverwrite,
  // Interrupt pads
  output logic pad1Out,
  output logic pad1Drive_n,
  output logic pad2Out,
  output logic pad2Drive_n
);
  import sensor_ctrl_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rstMeta;
  logic rstSync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic [7:0] padCfg;
  logic [7:0] pad1Route;
  logic [7:0] pad2Route;
  logic [7:0] queueCtrl;

  wire logic hitCfg = paddr == {IDX_PAD_CFG, 2'b00};
  wire logic hitR1 = paddr == {IDX_PAD1_ROUTE, 2'b00};
  wire logic hitR2 = paddr == {IDX_PAD2_ROUTE, 2'b00};
  wire logic hitQ = paddr == {IDX_QUEUE_CTRL, 2'b00};
  wire logic mapped = hitCfg | hitR1 | hitR2 | hitQ;
  wire logic setup = psel & ~penable;
  wire logic done = psel & penable & pready;
  wire logic wr = done & pwrite & mapped & pstrb[0];
  wire logic [7:0] wdata = pwdata[7:0];
  wire logic [7:0] rdSel = hitCfg ? padCfg :
                           hitR1 ? pad1Route :
                           hitR2 ? pad2Route :
                           hitQ ? queueCtrl : 8'h00;

  // No wait state: data is captured in setup, answered in the first access cycle
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= {24'h00_0000, rdSel};
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      padCfg <= REG_RESET;
      pad1Route <= REG_RESET;
      pad2Route <= REG_RESET;
      queueCtrl <= REG_RESET;
    end
    else if (softReset)
    begin
      padCfg <= REG_RESET;
      pad1Route <= REG_RESET;
      pad2Route <= REG_RESET;
      queueCtrl <= REG_RESET;
    end
    else if (wr)
    begin
      if (hitCfg)
        padCfg <= wdata;
      if (hitR1)
        pad1Route <= wdata;
      if (hitR2)
        pad2Route <= wdata;
      // Reserved bits are forced low in case the host ignores them
      if (hitQ)
        queueCtrl <= wdata & QUEUE_WMASK;
    end
  end

  wire logic latchMode = padCfg[F_LATCH];
  wire logic polLow = padCfg[F_POL_LOW];
  wire logic openDrain = padCfg[F_DRIVE];
  wire logic readyPulsed = pad2Route[F2_PULSE];
  wire logic [2:0] modeField = queueCtrl[FQ_MODE +: 3];

  // ------------------------------------------------------------
  // Event latching
  // ------------------------------------------------------------
  logic [EV_N-1:0] held;
  logic readyHeld;
  wire logic [EV_N-1:0] evIn = {stepEvent, sigMotionEvent, tiltEvent,
                                doubleTapEvent, singleTapEvent, wakeupEvent};

  // Set beats clear so an event coinciding with a read is kept
  genvar gi;
  generate
    for (gi = 0; gi < EV_N; gi++)
    begin : g_ev
      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          held[gi] <= 1'b0;
        else if (latchMode)
          held[gi] <= evIn[gi] | (held[gi] & ~latchClear);
        else
          held[gi] <= evIn[gi];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      readyHeld <= 1'b0;
    else if (readyPulsed)
      readyHeld <= sampleReady;
    else
      readyHeld <= sampleReady | (readyHeld & ~readyAck);
  end

  // ------------------------------------------------------------
  // Pad routing
  // ------------------------------------------------------------
  wire logic pad2Level = (bootBusy & pad2Route[F2_BOOT])
    | (held[EV_TILT] & pad2Route[F2_TILT])
    | (held[EV_SIGMOT] & pad2Route[F2_SIGMOT])
    | (held[EV_STEP] & pad2Route[F2_STEP])
    | (queueLevelHit & pad2Route[F2_LEVEL])
    | (readyHeld & pad2Route[F2_READY])
    | (stepOverflow & queueCtrl[FQ_STEP_OV]);

  wire logic pad1Level = (masterReady & pad1Route[F1_MASTER])
    | (held[EV_STAP] & pad1Route[F1_STAP])
    | (held[EV_WAKE] & pad1Route[F1_WAKE])
    | (freefallLevel & pad1Route[F1_FALL])
    | (held[EV_DTAP] & pad1Route[F1_DTAP])
    | (orientLevel & pad1Route[F1_ORIENT])
    | (queueLevelHit & pad1Route[F1_LEVEL])
    | (readyHeld & pad1Route[F1_READY])
    | (pad2Level & pad2Route[F2_MERGE]);

  wire logic pad1Val = pad1Level ^ polLow;
  wire logic pad2Val = pad2Level ^ polLow;

  // Open-drain only ever pulls low; the wire floats for a one
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      pad1Out <= 1'b0;
      pad1Drive_n <= 1'b0;
      pad2Out <= 1'b0;
      pad2Drive_n <= 1'b0;
    end
    else
    begin
      pad1Out <= openDrain ? 1'b0 : pad1Val;
      pad1Drive_n <= openDrain & pad1Val;
      pad2Out <= openDrain ? 1'b0 : pad2Val;
      pad2Drive_n <= openDrain & pad2Val;
    end
  end

  // ------------------------------------------------------------
  // Queue mode sequencer
  // ------------------------------------------------------------
  queue_state_e qState;
  queue_state_e next_qState;
  queue_state_e entryState;
  logic trigPrev;

  wire logic modeWrite = wr & hitQ;
  wire logic trigFall = trigPrev & ~queueTrigger;

  always_comb
  begin
    case (wdata[FQ_MODE +: 3])
      MODE_BYPASS: entryState = Q_OFF;
      MODE_STOP_FULL: entryState = Q_STOP;
      MODE_STREAM_TO_STOP: entryState = Q_PRE_STOP;
      MODE_BYPASS_TO_STOP: entryState = Q_HOLD_OFF;
      MODE_STREAM: entryState = Q_STREAM;
      default: entryState = Q_OFF;
    endcase
  end

  always_comb
  begin
    next_qState = qState;
    if (softReset)
      next_qState = Q_OFF;
    else if (modeWrite)
      next_qState = entryState;
    else
    begin
      case (qState)
        Q_PRE_STOP: if (trigFall) next_qState = Q_STOP;
        Q_HOLD_OFF: if (trigFall) next_qState = Q_STOP;
        Q_OFF, Q_STOP, Q_STREAM: next_qState = qState;
        default: next_qState = Q_OFF;
      endcase
    end
  end

  wire logic streaming = (qState == Q_STREAM) | (qState == Q_PRE_STOP);
  wire logic accept = streaming | ((qState == Q_STOP) & ~queueFull);
  wire logic [9:0] capSel = queueCtrl[FQ_MAGNITUDE] ? 10'(MAG_ENTRIES) : 10'(AXIS_ENTRIES);

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      qState <= Q_OFF;
      trigPrev <= 1'b0;
      queueWrite <= 1'b0;
      queueOverwrite <= 1'b0;
      queueEnabled <= 1'b0;
    end
    else
    begin
      qState <= next_qState;
      trigPrev <= queueTrigger;
      queueWrite <= sampleReady & accept;
      queueOverwrite <= sampleReady & streaming & queueFull;
      queueEnabled <= accept | (qState == Q_STOP);
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      selfTestSelect <= SELF_TEST_OFF;
      tapAxisEnable <= 3'h0;
      magnitudeToQueue <= 1'b0;
      queueCapacity <= 10'(AXIS_ENTRIES);
      csPullupDisable <= 1'b0;
    end
    else
    begin
      selfTestSelect <= padCfg[F_SELF_TEST +: 2];
      tapAxisEnable <= padCfg[F_TAP_Z +: 3];
      magnitudeToQueue <= queueCtrl[FQ_MAGNITUDE];
      queueCapacity <= capSel;
      csPullupDisable <= queueCtrl[FQ_PULLUP];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync_n);

  property p_selftest;
    wr & hitCfg & ~softReset |=> ##1 selfTestSelect == $past(wdata[7:6], 2);
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test field wrong");

  property p_tap;
    wr & hitCfg & ~softReset |=> ##1 tapAxisEnable == $past(wdata[5:3], 2);
  endproperty
  a_tap: assert property (p_tap) else $error("tap enables wrong");

  property p_latch;
    latchMode & held[EV_STAP] & ~latchClear |=> held[EV_STAP];
  endproperty
  a_latch: assert property (p_latch) else $error("latched event dropped");

  property p_pulse;
    ~latchMode & ~evIn[EV_WAKE] |=> ~held[EV_WAKE];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulsed event stuck");

  property p_pol;
    ~openDrain & ~polLow & held[EV_STAP] & pad1Route[F1_STAP] |=> pad1Out;
  endproperty
  a_pol: assert property (p_pol) else $error("pad1 not asserted high");

  property p_od;
    openDrain |=> ~pad1Out & ~pad2Out;
  endproperty
  a_od: assert property (p_od) else $error("open-drain drove high");

  property p_merge;
    ~openDrain & ~polLow & pad2Route[F2_MERGE] & pad2Level |=> pad1Out;
  endproperty
  a_merge: assert property (p_merge) else $error("merge failed");

  property p_ready;
    readyPulsed & ~sampleReady |=> ~readyHeld;
  endproperty
  a_ready: assert property (p_ready) else $error("pulsed ready held");

  property p_bypass;
    qState == Q_OFF |=> ~queueWrite;
  endproperty
  a_bypass: assert property (p_bypass) else $error("write in bypass");

  property p_stopfull;
    qState == Q_STOP & queueFull |=> ~queueWrite;
  endproperty
  a_stopfull: assert property (p_stopfull) else $error("write when full");

  property p_stream;
    qState == Q_STREAM & queueFull & sampleReady |=> queueWrite & queueOverwrite;
  endproperty
  a_stream: assert property (p_stream) else $error("overwrite missing");

  property p_switch;
    qState == Q_PRE_STOP & trigFall & ~modeWrite & ~softReset |=> qState == Q_STOP;
  endproperty
  a_switch: assert property (p_switch) else $error("no switch to stop");

  property p_source;
    queueWrite |-> $past(sampleReady);
  endproperty
  a_source: assert property (p_source) else $error("write without sample");

  property p_cap;
    queueCtrl[FQ_MAGNITUDE] |=> queueCapacity == 10'(MAG_ENTRIES);
  endproperty
  a_cap: assert property (p_cap) else $error("capacity wrong");

  c_write: cover property (queueWrite ##1 queueOverwrite);
  c_pad1: cover property (pad1Out ##1 ~pad1Out);
  c_latch: cover property (latchMode & held[EV_TILT] ##3 held[EV_TILT]);
  c_apb: cover property (wr & hitQ);

endmodule

`default_nettype wire

// >>> rtl/sensor_ctrl_pkg.sv
package sensor_ctrl_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_PAD_CFG = 6'h22;
  localparam logic [5:0] IDX_PAD1_ROUTE = 6'h23;
  localparam logic [5:0] IDX_PAD2_ROUTE = 6'h24;
  localparam logic [5:0] IDX_QUEUE_CTRL = 6'h25;

  // ------------------------------------------------------------
  // Pad and self-test configuration fields
  // ------------------------------------------------------------
  localparam int F_SELF_TEST = 6;
  localparam int F_TAP_X = 5;
  localparam int F_TAP_Z = 3;
  localparam int F_LATCH = 2;
  localparam int F_POL_LOW = 1;
  localparam int F_DRIVE = 0;
  localparam logic [1:0] SELF_TEST_OFF = 2'h0;

  // ------------------------------------------------------------
  // First pad routing fields
  // ------------------------------------------------------------
  localparam int F1_MASTER = 7;
  localparam int F1_STAP = 6;
  localparam int F1_WAKE = 5;
  localparam int F1_FALL = 4;
  localparam int F1_DTAP = 3;
  localparam int F1_ORIENT = 2;
  localparam int F1_LEVEL = 1;
  localparam int F1_READY = 0;

  // ------------------------------------------------------------
  // Second pad routing fields
  // ------------------------------------------------------------
  localparam int F2_PULSE = 7;
  localparam int F2_BOOT = 6;
  localparam int F2_MERGE = 5;
  localparam int F2_TILT = 4;
  localparam int F2_SIGMOT = 3;
  localparam int F2_STEP = 2;
  localparam int F2_LEVEL = 1;
  localparam int F2_READY = 0;

  // ------------------------------------------------------------
  // Queue control fields
  // ------------------------------------------------------------
  localparam int FQ_MODE = 5;
  localparam int FQ_STEP_OV = 4;
  localparam int FQ_MAGNITUDE = 3;
  localparam int FQ_PULLUP = 0;
  localparam logic [7:0] QUEUE_WMASK = 8'hF9;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int AXIS_DEPTH = 256;
  localparam int MAG_DEPTH = 768;

  // ------------------------------------------------------------
  // Latched event slots
  // ------------------------------------------------------------
  localparam int EV_WAKE = 0;
  localparam int EV_STAP = 1;
  localparam int EV_DTAP = 2;
  localparam int EV_TILT = 3;
  localparam int EV_SIGMOT = 4;
  localparam int EV_STEP = 5;
  localparam int EV_N = 6;

  typedef enum logic [2:0] {
    MODE_BYPASS = 3'b000,
    MODE_STOP_FULL = 3'b001,
    MODE_STREAM_TO_STOP = 3'b011,
    MODE_BYPASS_TO_STOP = 3'b100,
    MODE_STREAM = 3'b110
  } queue_mode_e;

  typedef enum logic [2:0] {
    Q_OFF = 3'b000,
    Q_STOP = 3'b001,
    Q_STREAM = 3'b010,
    Q_PRE_STOP = 3'b011,
    Q_HOLD_OFF = 3'b100
  } queue_state_e;

endpackage

// >>> sim/interrupt_selftest_fifo_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module interrupt_selftest_fifo_control_tb_top;
  import sensor_ctrl_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic softReset = 1'b0;
  logic latchClear = 1'b0;
  logic readyAck = 1'b0;
  // Event pulses, status levels and sample-ready in one vector
  logic [12:0] src = 13'h0;
  logic queueFull = 1'b0;
  logic queueTrigger = 1'b0;
  logic inv = 1'b0;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  wire logic pready, pslverr, magnitudeToQueue, csPullupDisable, queueEnabled, queueWrite, queueOverwrite;
  wire logic pad1Out, pad1Drive_n, pad2Out, pad2Drive_n, lvl1, lvl2;
  wire logic [31:0] prdata;
  wire logic [1:0] selfTestSelect;
  wire logic [2:0] tapAxisEnable;
  wire logic [9:0] queueCapacity;

  always #4 clock = ~clock;

  sensor_ctrl i_sensor_ctrl (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .softReset(softReset), .latchClear(latchClear), .readyAck(readyAck),
    .wakeupEvent(src[0]), .singleTapEvent(src[1]), .doubleTapEvent(src[2]), .tiltEvent(src[3]),
    .sigMotionEvent(src[4]), .stepEvent(src[5]), .freefallLevel(src[6]), .orientLevel(src[7]),
    .masterReady(src[8]), .bootBusy(src[9]), .stepOverflow(src[10]), .queueLevelHit(src[11]),
    .sampleReady(src[12]), .queueFull(queueFull), .queueTrigger(queueTrigger),
    .selfTestSelect(selfTestSelect), .tapAxisEnable(tapAxisEnable), .magnitudeToQueue(magnitudeToQueue),
    .queueCapacity(queueCapacity), .csPullupDisable(csPullupDisable), .queueEnabled(queueEnabled),
    .queueWrite(queueWrite), .queueOverwrite(queueOverwrite), .pad1Out(pad1Out),
    .pad1Drive_n(pad1Drive_n), .pad2Out(pad2Out), .pad2Drive_n(pad2Drive_n)
  );
  pad_host_monitor i_pad_host_monitor1 (.padOut(pad1Out), .padDrive_n(pad1Drive_n), .padLevel(lvl1));
  pad_host_monitor i_pad_host_monitor2 (.padOut(pad2Out), .padDrive_n(pad2Drive_n), .padLevel(lvl2));

  // ----------------------------------------
  // Compare, bus and pulse helpers
  // ----------------------------------------
  task automatic complete_run();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic checkBit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd, input logic [3:0] st);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 4'hF);
  endtask

  task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, 4'hF);
    check(name, exp, rd);
  endtask

  task automatic fire(input int idx);
    @(posedge clock);
    src[idx] <= 1'b1;
    @(posedge clock);
    src[idx] <= 1'b0;
  endtask

  // Source reaches the pad one edge after it is sampled; h means it stays latched
  task automatic route(input logic [7:0] r1, input logic [7:0] r2, input int idx, input logic e1,
                       input logic e2, input logic h);
    wr(IDX_PAD1_ROUTE, r1);
    wr(IDX_PAD2_ROUTE, r2);
    // Levels skip the capture stage, so they stand two cycles to line up
    @(posedge clock);
    src[idx] <= 1'b1;
    @(posedge clock);
    if (idx < 6 || idx > 11)
      src[idx] <= 1'b0;
    @(posedge clock);
    src[idx] <= 1'b0;
    #1;
    checkBit("pad1 asserted", e1 ^ inv, lvl1);
    checkBit("pad2 asserted", e2 ^ inv, lvl2);
    @(posedge clock);
    #1;
    checkBit("pad1 next cycle", (e1 & h) ^ inv, lvl1);
    checkBit("pad2 next cycle", (e2 & h) ^ inv, lvl2);
    @(posedge clock);
    latchClear <= 1'b1;
    readyAck <= 1'b1;
    @(posedge clock);
    latchClear <= 1'b0;
    readyAck <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    checkBit("pad1 cleared", inv, lvl1);
    checkBit("pad2 cleared", inv, lvl2);
  endtask

  task automatic sample(input logic full, input logic ew, input logic eo);
    @(posedge clock);
    queueFull <= full;
    src[12] <= 1'b1;
    @(posedge clock);
    src[12] <= 1'b0;
    #1;
    checkBit("queue write", ew, queueWrite);
    checkBit("queue overwrite", eo, queueOverwrite);
  endtask

  task automatic trig(input logic v);
    @(posedge clock);
    queueTrigger <= v;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    rdchk("cfg reset", IDX_PAD_CFG, 32'h0);
    rdchk("pad1 route reset", IDX_PAD1_ROUTE, 32'h0);
    rdchk("pad2 route reset", IDX_PAD2_ROUTE, 32'h0);
    rdchk("queue reset", IDX_QUEUE_CTRL, 32'h0);
    check("capacity reset", 32'd256, {22'h0, queueCapacity});
    wr(IDX_PAD_CFG, 8'h78);
    rdchk("cfg readback", IDX_PAD_CFG, 32'h78);
    check("self test plus", 32'h1, {30'h0, selfTestSelect});
    check("tap axes", 32'h7, {29'h0, tapAxisEnable});
    wr(IDX_PAD_CFG, 8'hB0);
    rdchk("cfg readback", IDX_PAD_CFG, 32'hB0);
    check("self test minus", 32'h2, {30'h0, selfTestSelect});
    check("tap x y", 32'h6, {29'h0, tapAxisEnable});
    wr(IDX_QUEUE_CTRL, 8'h19);
    rdchk("queue readback", IDX_QUEUE_CTRL, 32'h19);
    checkBit("magnitude", 1'b1, magnitudeToQueue);
    check("capacity magnitude", 32'd768, {22'h0, queueCapacity});
    checkBit("pull-up off", 1'b1, csPullupDisable);
    apb(1'b1, IDX_PAD1_ROUTE, 8'hFF, 4'h0);
    rdchk("strobe off write", IDX_PAD1_ROUTE, 32'h0);
    apb(1'b0, 6'h26, 8'h00, 4'hF);
    checkBit("unmapped error", 1'b1, err);
    check("unmapped data", 32'h0, rd);
    @(posedge clock);
    softReset <= 1'b1;
    @(posedge clock);
    softReset <= 1'b0;
    rdchk("cfg soft reset", IDX_PAD_CFG, 32'h0);
    rdchk("queue soft reset", IDX_QUEUE_CTRL, 32'h0);
  endtask

  task automatic test_routes();
    route(8'h40, 8'h00, 1, 1'b1, 1'b0, 1'b0);
    route(8'h20, 8'h00, 0, 1'b1, 1'b0, 1'b0);
    route(8'h10, 8'h00, 6, 1'b1, 1'b0, 1'b0);
    route(8'h08, 8'h00, 2, 1'b1, 1'b0, 1'b0);
    route(8'h04, 8'h00, 7, 1'b1, 1'b0, 1'b0);
    route(8'hBF, 8'h00, 3, 1'b0, 1'b0, 1'b0);
    route(8'h80, 8'h00, 8, 1'b1, 1'b0, 1'b0);
    route(8'h02, 8'h00, 11, 1'b1, 1'b0, 1'b0);
    route(8'h01, 8'h00, 12, 1'b1, 1'b0, 1'b1);
    route(8'h00, 8'h81, 12, 1'b0, 1'b1, 1'b0);
    route(8'h00, 8'h10, 3, 1'b0, 1'b1, 1'b0);
    route(8'h00, 8'h08, 4, 1'b0, 1'b1, 1'b0);
    route(8'h00, 8'h04, 5, 1'b0, 1'b1, 1'b0);
    route(8'h00, 8'h40, 9, 1'b0, 1'b1, 1'b0);
    route(8'h00, 8'h02, 11, 1'b0, 1'b1, 1'b0);
    route(8'h00, 8'h30, 3, 1'b1, 1'b1, 1'b0);
    wr(IDX_QUEUE_CTRL, 8'h10);
    route(8'h00, 8'h00, 10, 1'b0, 1'b1, 1'b0);
    wr(IDX_QUEUE_CTRL, 8'h00);
  endtask

  task automatic test_pad_modes();
    wr(IDX_PAD_CFG, 8'h04);
    route(8'h40, 8'h00, 1, 1'b1, 1'b0, 1'b1);
    route(8'h00, 8'h10, 3, 1'b0, 1'b1, 1'b1);
    wr(IDX_PAD_CFG, 8'h02);
    inv = 1'b1;
    route(8'h40, 8'h00, 1, 1'b1, 1'b0, 1'b0);
    inv = 1'b0;
    wr(IDX_PAD_CFG, 8'h01);
    fire(1);
    @(posedge clock);
    #1;
    checkBit("open-drain released", 1'b1, pad1Drive_n);
    checkBit("open-drain data", 1'b0, pad1Out);
    checkBit("idle pad2 pulls low", 1'b0, pad2Drive_n);
    wr(IDX_PAD_CFG, 8'h00);
  endtask

  task automatic test_queue();
    sample(1'b0, 1'b0, 1'b0);
    wr(IDX_QUEUE_CTRL, 8'h20);
    @(posedge clock);
    #1;
    checkBit("queue enabled", 1'b1, queueEnabled);
    sample(1'b0, 1'b1, 1'b0);
    sample(1'b1, 1'b0, 1'b0);
    wr(IDX_QUEUE_CTRL, 8'hC0);
    sample(1'b1, 1'b1, 1'b1);
    trig(1'b1);
    wr(IDX_QUEUE_CTRL, 8'h60);
    sample(1'b1, 1'b1, 1'b1);
    trig(1'b0);
    sample(1'b1, 1'b0, 1'b0);
    trig(1'b1);
    wr(IDX_QUEUE_CTRL, 8'h80);
    sample(1'b0, 1'b0, 1'b0);
    trig(1'b0);
    sample(1'b0, 1'b1, 1'b0);
    // Reserved mode code must fall back to bypass
    wr(IDX_QUEUE_CTRL, 8'hA0);
    sample(1'b0, 1'b0, 1'b0);
    wr(IDX_QUEUE_CTRL, 8'h20);
    wr(IDX_QUEUE_CTRL, 8'h00);
    @(posedge clock);
    #1;
    checkBit("queue disabled", 1'b0, queueEnabled);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_regs();
    test_routes();
    test_pad_modes();
    test_queue();
    complete_run();
  end
endmodule

`default_nettype wire

// >>> sim/pad_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host view of one interrupt pad
// ----------------------------------------
module pad_host_monitor (
  // Pad pins from the device
  input wire logic padOut,
  input wire logic padDrive_n,
  // Level the host sees on the wire
  output logic padLevel
);
  // Board pull-up holds the wire high once the pad lets go
  assign padLevel = padDrive_n ? 1'b1 : padOut;
endmodule

`default_nettype wire
